// ### core/skip_or_move_instruction_exec.sv
// Executor for skip, or and move instructions of an 8-bit core
`timescale 1ns/1ps
`default_nettype none
module skip_or_move_instruction_exec
    import skip_exec_pkg::*;
#(
    parameter int DEPTH = FILE_DEPTH
)
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic insn_valid_in,
    input wire logic [INSN_W-1:0] insn_in,
    input wire logic file_wr_in,
    input wire logic [ADDR_W-1:0] file_addr_in,
    input wire logic [DATA_W-1:0] file_data_in,
    output logic [DATA_W-1:0] acc_out,
    output logic zero_flag_out,
    output logic skipping_out,
    output logic retired_out,
    output logic [DATA_W-1:0] file_rd_data_out
);
    // Decoded fields travel from the decoder on this bundle
    decode_if dif();
    // Sequencer and architectural state
    exec_state_e state_q;
    exec_state_e state_d;
    logic [DATA_W-1:0] acc_q;
    logic zero_q;
    // File registers are plain flops without reset; preload them from the side port
    logic [DATA_W-1:0] file_q [DEPTH];
    // Datapath and control for the slot now presented
    logic [DATA_W-1:0] operand;
    logic [DATA_W-1:0] result;
    logic execute;
    logic counter_op;
    logic write_file;
    logic write_acc;
    logic write_zero;
    logic take_skip;
    logic retired_q;

    // Zero test shared by flag update and skip decision
    // Kept in one place so the flag and the skip can never disagree
    function automatic logic is_zero(input logic [DATA_W-1:0] v);
        return v == ZERO_BYTE;
    endfunction

    // Decoder is purely combinational; fields follow insn_in in the same cycle
    // A word that matches no known op retires with no effect
    insn_decoder u_dec (
        .insn_in(insn_in),
        .dec(dif.dec)
    );

    // File operand read straight from the addressed flop
    assign operand = file_q[dif.file_addr];
    // A slot that is being skipped executes nothing at all
    // An invalid cycle neither executes nor consumes a pending squash
    assign execute = insn_valid_in && (state_q == ST_EXEC);

    // Result of the decoded operation
    // Counters wrap modulo 256, which is what the skip test relies on
    always_comb
    begin
        case (dif.kind)
            OP_DEC_SKIP: result = operand - ONE_BYTE;
            OP_INC_SKIP: result = operand + ONE_BYTE;
            OP_OR_LIT: result = acc_q | dif.literal;
            OP_LOAD_LIT: result = dif.literal;
            OP_OR_FILE: result = acc_q | operand;
            OP_STORE: result = acc_q;
            // Unknown codes pass the accumulator through; nothing is written
            default: result = acc_q;
        endcase
    end

    // Destination routing; only the OR forms touch the zero flag
    always_comb
    begin
        write_file = 1'b0;
        write_acc = 1'b0;
        write_zero = 1'b0;
        case (dif.kind)
            OP_DEC_SKIP, OP_INC_SKIP:
            begin
                // Counters never touch the zero flag
                write_file = dif.dest_file;
                write_acc = !dif.dest_file;
            end
            OP_OR_FILE:
            begin
                // Zero flag follows the OR result whichever way it is routed
                write_file = dif.dest_file;
                write_acc = !dif.dest_file;
                write_zero = 1'b1;
            end
            OP_OR_LIT:
            begin
                // Literal forms always land in the accumulator
                write_acc = 1'b1;
                write_zero = 1'b1;
            end
            OP_LOAD_LIT:
            begin
                write_acc = 1'b1;
            end
            OP_STORE:
            begin
                // Store has no accumulator form; its destination bit is fixed
                write_file = 1'b1;
            end
            default:
            begin
                // Unknown code: retire with no architectural effect
                write_acc = 1'b0;
            end
        endcase
    end

    // Only the two counter forms can arm a skip
    assign counter_op = (dif.kind == OP_DEC_SKIP) || (dif.kind == OP_INC_SKIP);

    // Skip on a zero counter result only; the test sees the wrapped 8-bit value
    assign take_skip = execute && counter_op && is_zero(result);

    // Skip sequencer: the next valid slot after a taken skip is a no-op
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_EXEC:
            begin
                // Arm the squash only when a counter lands on zero
                if (take_skip)
                    state_d = ST_SKIP;
            end
            ST_SKIP:
            begin
                // Idle cycles leave the squash armed for the next real slot
                if (insn_valid_in)
                    state_d = ST_EXEC;
            end
            default:
            begin
                // Illegal code: recover to normal execution
                state_d = ST_EXEC;
            end
        endcase
    end

    // Sequencer state; reset leaves no squash pending
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            state_q <= ST_EXEC;
        else
            state_q <= state_d;
    end

    // Accumulator; reset clears it so an early OR sees a known value
    // Written by loads, the literal OR, and the file OR and counters when routed to it
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            acc_q <= ZERO_BYTE;
        else if (execute && write_acc)
            acc_q <= result;
    end

    // Zero flag; untouched by counters, loads and stores
    // Reset clears it; it reflects no instruction until an OR runs
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            zero_q <= 1'b0;
        else if (execute && write_zero)
            zero_q <= is_zero(result);
    end

    // File registers; side port preloads, no reset so contents start unknown
    always_ff @(posedge clk_in)
    begin
        if (file_wr_in)
            file_q[file_addr_in] <= file_data_in;
        // Core write comes last so it wins only when both hit one address
        if (execute && write_file)
            file_q[dif.file_addr] <= result;
    end

    // Retire pulse, one per executed instruction slot
    // Squashed and idle slots leave it low
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            retired_q <= 1'b0;
        else
            retired_q <= execute;
    end

    // Architectural state straight from its flops
    assign acc_out = acc_q;
    assign zero_flag_out = zero_q;
    assign retired_out = retired_q;

    // Squash pending; tells the fetch side the next valid slot is a no-op
    assign skipping_out = (state_q == ST_SKIP);

    // Side read is a mux over flops, so it follows file_addr_in in the same cycle
    assign file_rd_data_out = file_q[file_addr_in];
endmodule
`default_nettype wire

// ### core/skip_exec_pkg.sv
// Constants and types for the skip-or-move instruction executor
package skip_exec_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int INSN_W = 14;
    localparam int FILE_DEPTH = 128;
    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
    localparam logic [DATA_W-1:0] ONE_BYTE = 8'h01;
    // Opcode field positions within the 14-bit instruction word
    localparam int OP_BYTE_HI = 13;
    localparam int OP_BYTE_LO = 8;
    localparam int DEST_BIT = 7;
    localparam int OP_LIT_HI = 13;
    localparam int OP_LIT_LO = 10;
    // Byte-oriented opcodes (bits 13:8)
    localparam logic [5:0] OPC_DECREMENT_SKIP_ZERO = 6'h0b;
    localparam logic [5:0] OPC_INCREMENT_SKIP_ZERO = 6'h0f;
    localparam logic [5:0] OPC_OR_ACC_WITH_FILE = 6'h04;
    localparam logic [5:0] OPC_STORE_ACC_TO_FILE = 6'h00;
    // Literal opcodes (bits 13:10 for load, 13:8 for or)
    localparam logic [3:0] OPC_LOAD_LITERAL_INTO_ACC = 4'hc;
    localparam logic [5:0] OPC_OR_LITERAL_INTO_ACC = 6'h38;

    typedef enum logic [6:0] {
        OP_NONE = 7'h01,
        OP_DEC_SKIP = 7'h02,
        OP_INC_SKIP = 7'h04,
        OP_OR_LIT = 7'h08,
        OP_LOAD_LIT = 7'h10,
        OP_OR_FILE = 7'h20,
        OP_STORE = 7'h40
    } op_kind_e;

    typedef enum logic [1:0] {
        ST_EXEC = 2'h1,
        ST_SKIP = 2'h2
    } exec_state_e;
endpackage

// ### core/decode_if.sv
// Decoded instruction fields passed from decoder to executor
`timescale 1ns/1ps
`default_nettype none
interface decode_if;
    import skip_exec_pkg::*;
    op_kind_e kind;
    logic dest_file;
    logic [ADDR_W-1:0] file_addr;
    logic [DATA_W-1:0] literal;
    modport dec (output kind, output dest_file, output file_addr, output literal);
    modport exe (input kind, input dest_file, input file_addr, input literal);
endinterface
`default_nettype wire

// ### core/insn_decoder.sv
// Combinational instruction decoder for the six supported instructions
`timescale 1ns/1ps
`default_nettype none
module insn_decoder
    import skip_exec_pkg::*;
(
    input wire logic [INSN_W-1:0] insn_in,
    decode_if.dec dec
);
    logic [5:0] op6;

    assign op6 = insn_in[OP_BYTE_HI:OP_BYTE_LO];
    assign dec.dest_file = insn_in[DEST_BIT];
    assign dec.file_addr = insn_in[ADDR_W-1:0];
    assign dec.literal = insn_in[DATA_W-1:0];

    // Opcode match; store has its destination bit fixed at one
    always_comb
    begin
        if (op6 == OPC_DECREMENT_SKIP_ZERO)
            dec.kind = OP_DEC_SKIP;
        else if (op6 == OPC_INCREMENT_SKIP_ZERO)
            dec.kind = OP_INC_SKIP;
        else if (op6 == OPC_OR_ACC_WITH_FILE)
            dec.kind = OP_OR_FILE;
        else if (op6 == OPC_STORE_ACC_TO_FILE && insn_in[DEST_BIT])
            dec.kind = OP_STORE;
        else if (op6 == OPC_OR_LITERAL_INTO_ACC)
            dec.kind = OP_OR_LIT;
        else if (insn_in[OP_LIT_HI:OP_LIT_LO] == OPC_LOAD_LITERAL_INTO_ACC)
            dec.kind = OP_LOAD_LIT;
        else
            dec.kind = OP_NONE;
    end
endmodule
`default_nettype wire

// ### tb/skip_or_move_instruction_exec_chk.sv
// Checker for the skip-or-move instruction executor
`timescale 1ns/1ps
`default_nettype none
module skip_exec_chk
    import skip_exec_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic insn_valid_in,
    input wire logic [INSN_W-1:0] insn_in,
    input wire logic [DATA_W-1:0] acc_out,
    input wire logic zero_flag_out,
    input wire logic skipping_out,
    input wire logic retired_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    // A slot is taken only when no squash is pending
    logic take;
    logic [5:0] op;
    assign take = insn_valid_in && !skipping_out;
    assign op = insn_in[13:8];
    a_load_lit: assert property (take && insn_in[13:10] == 4'hc |=> acc_out == $past(insn_in[7:0]) && $stable(zero_flag_out))
        else $error("literal load wrong");
    a_or_lit_acc: assert property (take && op == 6'h38 |=> acc_out == ($past(acc_out) | $past(insn_in[7:0])))
        else $error("literal or wrong");
    a_or_lit_zero: assert property (take && op == 6'h38 |=> zero_flag_out == (acc_out == 8'h00))
        else $error("zero flag wrong");
    a_dec_flags: assert property (take && op == 6'h0b |=> $stable(zero_flag_out))
        else $error("decrement-skip touched flag");
    a_inc_flags: assert property (take && op == 6'h0f |=> $stable(zero_flag_out))
        else $error("increment-skip touched flag");
    a_store_quiet: assert property (take && op == 6'h00 && insn_in[7] |=> $stable(acc_out) && $stable(zero_flag_out))
        else $error("store changed acc or flag");
    a_skip_set: assert property (take && (op == 6'h0b || op == 6'h0f) && !insn_in[7] |=> skipping_out == (acc_out == 8'h00))
        else $error("skip decision wrong");
    a_squash_slot: assert property (insn_valid_in && skipping_out |=> !retired_out && $stable(acc_out) && !skipping_out)
        else $error("squashed slot had effect");
    a_retire_one: assert property (take |=> retired_out)
        else $error("slot not retired");
endmodule
bind skip_or_move_instruction_exec skip_exec_chk u_chk (.clk_in(clk_in), .rst_in(rst_in),
    .insn_valid_in(insn_valid_in), .insn_in(insn_in), .acc_out(acc_out),
    .zero_flag_out(zero_flag_out), .skipping_out(skipping_out), .retired_out(retired_out));
`default_nettype wire

// ### tb/skip_or_move_instruction_exec_bench.sv
// Directed bench for the skip-or-move instruction executor
`timescale 1ns/1ps
`default_nettype none
module skip_or_move_instruction_exec_bench;
    import skip_exec_pkg::*;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic insn_valid_in = 1'b0;
    logic [INSN_W-1:0] insn_in = 14'h0000;
    logic file_wr_in = 1'b0;
    logic [ADDR_W-1:0] file_addr_in = 7'h00;
    logic [DATA_W-1:0] file_data_in = 8'h00;
    logic [DATA_W-1:0] acc_out, file_rd_data_out;
    logic zero_flag_out, skipping_out, retired_out;
    int n_fail = 0;
    int checks = 0;
    // 100 MHz clock
    always #5 clk_in = ~clk_in;
    skip_or_move_instruction_exec DUT (.clk_in(clk_in), .rst_in(rst_in),
        .insn_valid_in(insn_valid_in), .insn_in(insn_in), .file_wr_in(file_wr_in),
        .file_addr_in(file_addr_in), .file_data_in(file_data_in), .acc_out(acc_out),
        .zero_flag_out(zero_flag_out), .skipping_out(skipping_out),
        .retired_out(retired_out), .file_rd_data_out(file_rd_data_out));
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // One slot, then idle; results are sampled at the falling edge after
    task automatic ex(input logic [13:0] i);
        @(negedge clk_in);
        insn_in = i;
        insn_valid_in = 1'b1;
        @(negedge clk_in);
        insn_valid_in = 1'b0;
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(negedge clk_in);
        file_addr_in = a;
        file_data_in = d;
        file_wr_in = 1'b1;
        @(negedge clk_in);
        file_wr_in = 1'b0;
    endtask
    // Load leaves the flag alone, OR updates it
    task automatic t_literal;
        ex({6'h30, 8'h00});
        chk("zero", 8'(zero_flag_out), 8'h00);
        ex({6'h38, 8'h00});
        chk("zero", 8'(zero_flag_out), 8'h01);
        ex({6'h30, 8'hf0});
        chk("zero", 8'(zero_flag_out), 8'h01);
        ex({6'h38, 8'h0f});
        chk("acc", acc_out, 8'hff);
        chk("zero", 8'(zero_flag_out), 8'h00);
        ex({6'h3f, 8'h00});
        chk("acc", acc_out, 8'hff);
        chk("retired", 8'(retired_out), 8'h01);
    endtask
    // OR with file at the top address both ways, then store
    task automatic t_file;
        wr(7'h7f, 8'h81);
        ex({6'h30, 8'h42});
        ex({6'h04, 1'b1, 7'h7f});
        chk("file", file_rd_data_out, 8'hc3);
        chk("acc", acc_out, 8'h42);
        wr(7'h7f, 8'h00);
        ex({6'h30, 8'h00});
        ex({6'h04, 1'b0, 7'h7f});
        chk("zero", 8'(zero_flag_out), 8'h01);
        ex({6'h30, 8'h5a});
        ex({6'h00, 1'b1, 7'h7f});
        chk("file", file_rd_data_out, 8'h5a);
        chk("zero", 8'(zero_flag_out), 8'h01);
    endtask
    // Skip on file 5; the following load is squashed only on a zero result
    task automatic skp(input logic [5:0] op, input logic [7:0] init, input logic d,
        input logic [7:0] res);
        logic z;
        wr(7'h05, init);
        ex({6'h30, 8'ha5});
        z = zero_flag_out;
        ex({op, d, 7'h05});
        chk("dest", d ? file_rd_data_out : acc_out, res);
        chk("other", d ? acc_out : file_rd_data_out, d ? 8'ha5 : init);
        chk("zero", 8'(zero_flag_out), 8'(z));
        chk("skip", 8'(skipping_out), 8'(res == 8'h00));
        ex({6'h30, 8'h77});
        chk("retired", 8'(retired_out), 8'(res != 8'h00));
        chk("acc", acc_out, (res != 8'h00) ? 8'h77 : (d ? 8'ha5 : res));
        chk("skip", 8'(skipping_out), 8'h00);
    endtask
    task automatic finish_test;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        repeat (12) @(negedge clk_in);
        rst_in = 1'b0;
        t_literal();
        t_file();
        skp(6'h0b, 8'h01, 1'b1, 8'h00);
        skp(6'h0b, 8'h03, 1'b0, 8'h02);
        skp(6'h0f, 8'hff, 1'b0, 8'h00);
        skp(6'h0f, 8'h10, 1'b1, 8'h11);
        finish_test();
    end
    // Watchdog: the run needs about 70 cycles
    initial
    begin
        #50000;
        n_fail++;
        finish_test();
    end
endmodule
`default_nettype wire
